// ==== cazs_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cazs_adc_model (
   // converter control
   input  wire logic        clock_i,
   input  wire logic        start_i,
   input  wire logic [2:0]  mux_sel_i,
   input  wire logic        low_gain_i,
   input  wire logic [7:0]  offset_i,
   input  wire logic [11:0] level_i,
   input  wire logic [3:0]  ovf_ch_i,
   input  wire logic        slow_i,
   // results
   output var  logic [11:0] a_o,
   output var  logic        a_ovf_o,
   output var  logic [11:0] b_o,
   output var  logic        b_ovf_o
);
   logic [4:0]  cnt_reg = 5'h1f;
   logic [3:0]  m_reg = 4'h0;
   logic        g_reg = 1'b0;
   logic [7:0]  ofs_reg = 8'h00;
   logic [12:0] sum_a;
   logic [12:0] sum_b;
   logic        ok;
   always_ff @(posedge clock_i)
   begin
      if (start_i)
      begin
         m_reg <= {1'b0, mux_sel_i};
         g_reg <= low_gain_i;
         ofs_reg <= offset_i;
         cnt_reg <= 5'h00;
      end
      else if (cnt_reg != 5'h1f)
         cnt_reg <= cnt_reg + 5'h01;
   end
   // result stands only around the sample point
   always_comb
   begin
      sum_a = {1'b0, level_i} + {5'h00, m_reg, 4'h0} + {9'h000, g_reg, 3'h0} + {5'h00, ofs_reg};
      sum_b = sum_a + 13'h0080;
      ok = cnt_reg >= (slow_i ? 5'h10 : 5'h01) && cnt_reg <= 5'h16;
      a_o = ok ? sum_a[11:0] : ~sum_a[11:0];
      b_o = ok ? sum_b[11:0] : ~sum_b[11:0];
      a_ovf_o = !ok || sum_a[12] || m_reg == ovf_ch_i;
      b_ovf_o = !ok || sum_b[12] || m_reg + 4'h8 == ovf_ch_i;
   end
endmodule // cazs_adc_model
`default_nettype wire

// ==== cazs_pkg.sv ====
`default_nettype none
package cazs_pkg;
   ///////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_NS    = 40;
   localparam int CONV_NS   = 800;
   localparam int CONV_CYC  = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int DISCH_NS  = 2000;
   localparam int DISCH_CYC = (DISCH_NS + CLK_NS - 1) / CLK_NS;
   ///////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [15:0] OFS_MEB_END = 16'h07fc;
   localparam logic [15:0] OFS_CTRL    = 16'h1000;
   localparam logic [15:0] OFS_STAT    = 16'h1004;
   localparam logic [15:0] OFS_EVCNT   = 16'h1008;
   localparam logic [15:0] OFS_THR     = 16'h1080;
   localparam int          THR_SPAN_LSB = 6;
   ///////////////////////////////////////////////////////////////////////////
   // fields and values
   localparam int          CTRL_CLEAR = 3;
   localparam int          THR_KILL   = 8;
   localparam logic [11:0] SLIDE_MAX  = 12'hf00;
   localparam logic [2:0]  TYPE_DATA  = 3'h0;
   localparam logic [2:0]  TYPE_HEAD  = 3'h2;
   localparam logic [2:0]  TYPE_EOB   = 3'h4;
   localparam logic [2:0]  TYPE_INV   = 3'h6;
   localparam int          HEAD_CNT_LSB = 8;
   localparam logic [3:0]  B_CH_BASE  = 4'h8;
   ///////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_INTEG = 3'h1,
      ST_CONV  = 3'h3,
      ST_STA   = 3'h2,
      ST_STB   = 3'h6,
      ST_EOB   = 3'h7,
      ST_HEAD  = 3'h5,
      ST_DISCH = 3'h4
   } cazs_state_e;

   typedef struct packed {
      logic slide;
      logic res;
      logic keep;
   } cazs_cfg_s;

   localparam cazs_cfg_s CTRL_RST = 3'h0;
endpackage
`default_nettype wire

// ==== cazs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module cazs_properties (
   // clock and reset
   input wire logic       clock_i,
   input wire logic       rst_i,
   // watched ports
   input wire logic       gate_i,
   input wire logic       wb_ack_o,
   input wire logic       integrate_switch_o,
   input wire logic       discharge_switch_o,
   input wire logic       busy_o,
   input wire logic [2:0] mux_sel_o,
   input wire logic       low_gain_sel_o,
   input wire logic       adc_start_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   integ_gate_a: assert property ($rose(integrate_switch_o) |-> $past(gate_i) && busy_o) else $error("no gate");
   integ_end_a: assert property ($fell(integrate_switch_o) |-> ##[0:3] adc_start_o) else $error("no start");
   integ_excl_a: assert property (integrate_switch_o |-> !discharge_switch_o && !adc_start_o)
      else $error("integrate overlap");
   step_hold_a: assert property (adc_start_o |=> (!adc_start_o && $stable({mux_sel_o, low_gain_sel_o}))[*8])
      else $error("step disturbed");
   gain_pair_a: assert property (adc_start_o && !low_gain_sel_o |-> ##[20:26] (adc_start_o && low_gain_sel_o))
      else $error("no coarse step");
   disch_len_a: assert property ($rose(discharge_switch_o) |=> discharge_switch_o[*8]) else $error("short discharge");
   disch_quiet_a: assert property (discharge_switch_o |-> !adc_start_o && !integrate_switch_o && busy_o)
      else $error("discharge overlap");
   cover property (adc_start_o && low_gain_sel_o);
   cover property ($rose(discharge_switch_o));
   cover property (wb_ack_o);
endmodule // cazs_properties
bind cazs_top cazs_properties cazs_properties_i (.clock_i(clock_i), .rst_i(rst_i), .gate_i(gate_i),
   .wb_ack_o(wb_ack_o), .integrate_switch_o(integrate_switch_o), .discharge_switch_o(discharge_switch_o),
   .busy_o(busy_o), .mux_sel_o(mux_sel_o), .low_gain_sel_o(low_gain_sel_o), .adc_start_o(adc_start_o));
`default_nettype wire

// ==== cazs_top.sv ====
// Notes on behaviour
// - two words per channel, fine and coarse
// - store only unoverflowed, enabled values that pass threshold or are kept
// - two 12-bit converters, eight channels each
// - subtract sliding offset before threshold compare
// - corrected codes above 3840 are invalid
// - value at or above threshold is stored
// - below threshold stored only when keep enabled
// - stored below-threshold word sets bit 13
// - per-channel thresholds, reset to zero
// - coarse mode compares upper eight bits
// - fine mode uses bits 1-8, 9-11 zero
// - readable buffer holds thirty-two events
// - shared gate integrates, end starts conversion
// - discharge integrator after digitisation
// - skipped below-threshold words omitted from event
`timescale 1ns/1ps
`default_nettype none
module cazs_top #(
   parameter int EVENTS = 32
) (
   // clock and reset
   input  wire  logic        clock_i,
   input  wire  logic        rst_i,
   // wishbone slave
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [15:0] wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output       logic [31:0] wb_dat_o,
   output       logic        wb_ack_o,
   // front end
   input  wire  logic        gate_i,
   output       logic        integrate_switch_o,
   output       logic        discharge_switch_o,
   output       logic        busy_o,
   // converters
   output       logic [2:0]  mux_sel_o,
   output       logic        low_gain_sel_o,
   output       logic        adc_start_o,
   output       logic [7:0]  slide_offset_o,
   input  wire  logic [11:0] adc_a_i,
   input  wire  logic        adc_a_ovf_i,
   input  wire  logic [11:0] adc_b_i,
   input  wire  logic        adc_b_ovf_i
);
   ///////////////////////////////////////////////////////////////////////////
   localparam int CH    = 16;
   localparam int WORDS = 2 * CH + 2;
   localparam int EVW   = $clog2(EVENTS);
   localparam int IW    = $clog2(EVENTS * WORDS);

   typedef struct packed {
      logic [2:0]                   gsync;
      logic                         gate_q;
      cazs_pkg::cazs_state_e        st;
      cazs_pkg::cazs_cfg_s          ctrl;
      cazs_pkg::cazs_cfg_s          cfg;
      logic [CH-1:0][8:0]           thr;
      logic [7:0]                   slide;
      logic [5:0]                   cnt;
      logic [3:0]                   step;
      logic [7:0]                   tmr;
      logic [11:0]                  val_a;
      logic [11:0]                  val_b;
      logic                         ovf_a;
      logic                         ovf_b;
      logic [EVW-1:0]               wr_ev;
      logic [EVW-1:0]               rd_ev;
      logic [5:0]                   rd_word;
      logic                         full;
      logic [EVENTS-1:0][5:0]       len;
      logic [EVENTS*WORDS-1:0][31:0] mem;
      logic [23:0]                  evcnt;
      logic                         ack;
      logic [31:0]                  dat;
   } cazs_regs_s;

   cazs_regs_s r_reg;
   cazs_regs_s r_next;

   ///////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic below(input logic [11:0] v, input logic [7:0] t,
                                  input logic res);
      if (res)
         below = (v[11:9] == 3'h0) && (v[8:1] < t);
      else
         below = v[11:4] < t;
   endfunction

   function automatic logic [11:0] correct(input logic [11:0] raw,
                                           input logic [7:0] ofs,
                                           input logic en);
      correct = en ? raw - {4'h0, ofs} : raw;
   endfunction

   function automatic logic [IW-1:0] idx(input logic [EVW-1:0] ev,
                                         input logic [5:0] w);
      idx = IW'(int'(ev) * WORDS + int'(w));
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   logic [15:0] adr;
   logic        empty;
   logic        side_b;
   logic [11:0] raw;
   logic        raw_ovf;
   logic [11:0] corr;
   logic [3:0]  chan;
   logic        lim;
   logic        take;
   logic [3:0]  tch;

   always_comb
   begin
      r_next  = r_reg;
      adr     = {wb_adr_i[15:2], 2'b00};
      tch     = adr[5:2];
      empty   = (r_reg.wr_ev == r_reg.rd_ev) && !r_reg.full;
      side_b  = r_reg.st == cazs_pkg::ST_STB;
      raw     = side_b ? r_reg.val_b : r_reg.val_a;
      raw_ovf = side_b ? r_reg.ovf_b : r_reg.ovf_a;
      chan    = side_b ? {1'b0, r_reg.step[3:1]} + cazs_pkg::B_CH_BASE
                       : {1'b0, r_reg.step[3:1]};
      corr    = correct(raw, r_reg.slide, r_reg.cfg.slide);
      lim     = below(corr, r_reg.thr[chan][7:0], r_reg.cfg.res);
      take    = !raw_ovf
                && !(r_reg.cfg.slide && corr > cazs_pkg::SLIDE_MAX)
                && !r_reg.thr[chan][cazs_pkg::THR_KILL]
                && (!lim || r_reg.cfg.keep);

      ////////////////////////////////////////////////////////////////////////
      // gate synchroniser
      r_next.gsync = {r_reg.gsync[1:0], gate_i};
      if (r_reg.gsync[1] == r_reg.gsync[2])
         r_next.gate_q = r_reg.gsync[2];

      ////////////////////////////////////////////////////////////////////////
      // bus slave
      r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
      if (r_next.ack)
      begin
         r_next.dat = 32'h0000_0000;
         if (adr <= cazs_pkg::OFS_MEB_END)
            r_next.dat = empty ? {5'h00, cazs_pkg::TYPE_INV, 24'h00_0000}
                               : r_reg.mem[idx(r_reg.rd_ev, r_reg.rd_word)];
         else if (adr == cazs_pkg::OFS_CTRL)
            r_next.dat = {29'h0000_0000, r_reg.ctrl};
         else if (adr == cazs_pkg::OFS_STAT)
            r_next.dat = {29'h0000_0000, r_reg.full, !empty, busy_o};
         else if (adr == cazs_pkg::OFS_EVCNT)
            r_next.dat = {8'h00, r_reg.evcnt};
         else if (adr[15:cazs_pkg::THR_SPAN_LSB]
                  == cazs_pkg::OFS_THR[15:cazs_pkg::THR_SPAN_LSB])
            r_next.dat = {23'h00_0000, r_reg.thr[tch]};
      end

      if (r_reg.ack && wb_cyc_i && wb_stb_i)
      begin
         if (!wb_we_i && adr <= cazs_pkg::OFS_MEB_END && !empty)
         begin
            // reading the buffer walks the read pointer
            if (r_reg.rd_word + 6'h01 == r_reg.len[r_reg.rd_ev])
            begin
               r_next.rd_word = 6'h00;
               r_next.rd_ev   = r_reg.rd_ev + 1'b1;
               r_next.full    = 1'b0;
            end
            else
               r_next.rd_word = r_reg.rd_word + 6'h01;
         end
         if (wb_we_i && adr == cazs_pkg::OFS_CTRL && wb_sel_i[0])
         begin
            r_next.ctrl = cazs_pkg::cazs_cfg_s'(wb_dat_i[2:0]);
            if (wb_dat_i[cazs_pkg::CTRL_CLEAR])
            begin
               r_next.wr_ev   = '0;
               r_next.rd_ev   = '0;
               r_next.rd_word = 6'h00;
               r_next.full    = 1'b0;
               r_next.evcnt   = 24'h00_0000;
            end
         end
         if (wb_we_i && adr[15:cazs_pkg::THR_SPAN_LSB]
             == cazs_pkg::OFS_THR[15:cazs_pkg::THR_SPAN_LSB])
         begin
            if (wb_sel_i[0])
               r_next.thr[tch][7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
               r_next.thr[tch][cazs_pkg::THR_KILL] = wb_dat_i[cazs_pkg::THR_KILL];
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // conversion sequence
      case (r_reg.st)
         cazs_pkg::ST_IDLE:
         begin
            if (r_reg.gate_q && !r_reg.full)
            begin
               r_next.cfg   = r_reg.ctrl;
               r_next.evcnt = r_reg.evcnt + 24'h00_0001;
               r_next.st    = cazs_pkg::ST_INTEG;
            end
         end
         cazs_pkg::ST_INTEG:
         begin
            if (!r_reg.gate_q)
            begin
               r_next.st   = cazs_pkg::ST_CONV;
               r_next.step = 4'h0;
               r_next.tmr  = 8'h00;
               r_next.cnt  = 6'h00;
            end
         end
         cazs_pkg::ST_CONV:
         begin
            r_next.tmr = r_reg.tmr + 8'h01;
            if (r_reg.tmr == 8'(cazs_pkg::CONV_CYC))
            begin
               r_next.val_a = adc_a_i;
               r_next.ovf_a = adc_a_ovf_i;
               r_next.val_b = adc_b_i;
               r_next.ovf_b = adc_b_ovf_i;
               r_next.tmr   = 8'h00;
               r_next.st    = cazs_pkg::ST_STA;
            end
         end
         cazs_pkg::ST_STA, cazs_pkg::ST_STB:
         begin
            if (take)
            begin
               r_next.mem[idx(r_reg.wr_ev, r_reg.cnt + 6'h01)] =
                  {5'h00, cazs_pkg::TYPE_DATA, 3'h0, chan, r_reg.step[0],
                   2'h0, lim, 1'b0, corr};
               r_next.cnt = r_reg.cnt + 6'h01;
            end
            if (!side_b)
               r_next.st = cazs_pkg::ST_STB;
            else if (r_reg.step == 4'hf)
               r_next.st = cazs_pkg::ST_EOB;
            else
            begin
               r_next.step = r_reg.step + 4'h1;
               r_next.st   = cazs_pkg::ST_CONV;
            end
         end
         cazs_pkg::ST_EOB:
         begin
            r_next.tmr = 8'h00;
            if (r_reg.cnt != 6'h00)
            begin
               r_next.mem[idx(r_reg.wr_ev, r_reg.cnt + 6'h01)] =
                  {5'h00, cazs_pkg::TYPE_EOB, r_reg.evcnt};
               r_next.st = cazs_pkg::ST_HEAD;
            end
            else
               r_next.st = cazs_pkg::ST_DISCH;
         end
         cazs_pkg::ST_HEAD:
         begin
            r_next.mem[idx(r_reg.wr_ev, 6'h00)] =
               {5'h00, cazs_pkg::TYPE_HEAD, 10'h000, r_reg.cnt, 8'h00};
            r_next.len[r_reg.wr_ev] = r_reg.cnt + 6'h02;
            r_next.wr_ev = r_reg.wr_ev + 1'b1;
            if (r_reg.wr_ev + 1'b1 == r_next.rd_ev)
               r_next.full = 1'b1;
            r_next.st = cazs_pkg::ST_DISCH;
         end
         cazs_pkg::ST_DISCH:
         begin
            r_next.tmr = r_reg.tmr + 8'h01;
            if (r_reg.tmr == 8'(cazs_pkg::DISCH_CYC - 1))
            begin
               r_next.slide = r_reg.slide + 8'h01;
               r_next.st    = cazs_pkg::ST_IDLE;
            end
         end
         default:
            r_next.st = cazs_pkg::ST_IDLE;
      endcase
   end

   ///////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   ///////////////////////////////////////////////////////////////////////////
   // outputs
   assign wb_dat_o           = r_reg.dat;
   assign wb_ack_o           = r_reg.ack;
   assign integrate_switch_o = r_reg.st == cazs_pkg::ST_INTEG;
   assign discharge_switch_o = r_reg.st == cazs_pkg::ST_DISCH;
   assign busy_o             = (r_reg.st != cazs_pkg::ST_IDLE) || r_reg.full;
   assign mux_sel_o          = r_reg.step[3:1];
   assign low_gain_sel_o     = r_reg.step[0];
   assign adc_start_o        = (r_reg.st == cazs_pkg::ST_CONV) && (r_reg.tmr == 8'h00);
   assign slide_offset_o     = r_reg.cfg.slide ? r_reg.slide : 8'h00;
endmodule // cazs_top
`default_nettype wire

// ==== test_charge_adc_zero_suppression.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_charge_adc_zero_suppression;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [15:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } cazs_wbm_s;
   cazs_wbm_s   m = '0;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        gate = 1'b0;
   logic        slow = 1'b0;
   logic [11:0] lvl = 12'h0000;
   logic [7:0]  thr = 8'h18;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic        ack, integ, disch, busy, lg, start, aovf, bovf;
   logic [2:0]  mux;
   logic [7:0]  ofs;
   logic [11:0] a, b;
   int          bad_count = 0;
   int          compares = 0;
   int          evn = 0;
   cazs_top #(.EVENTS(4)) cazs_top_i (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(m.cyc), .wb_stb_i(m.stb),
      .wb_we_i(m.we), .wb_adr_i(m.adr), .wb_sel_i(m.sel), .wb_dat_i(m.dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .gate_i(gate), .integrate_switch_o(integ), .discharge_switch_o(disch), .busy_o(busy), .mux_sel_o(mux),
      .low_gain_sel_o(lg), .adc_start_o(start), .slide_offset_o(ofs), .adc_a_i(a), .adc_a_ovf_i(aovf),
      .adc_b_i(b), .adc_b_ovf_i(bovf));
   cazs_adc_model cazs_adc_model_i (.clock_i(clock_i), .start_i(start), .mux_sel_i(mux), .low_gain_i(lg),
      .offset_i(ofs), .level_i(lvl), .ovf_ch_i(4'h5), .slow_i(slow), .a_o(a), .a_ovf_o(aovf), .b_o(b),
      .b_ovf_o(bovf));
   always #20 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [15:0] wa, input logic [31:0] wd);
      @(posedge clock_i);
      m <= '{1'b1, 1'b1, w, wa, 4'hf, wd};
      do
      begin
         @(posedge clock_i);
      end
      while (ack !== 1'b1);
      rdat = dat_o;
      m <= '0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic event_run(input logic k, input logic r, input logic s, input logic [11:0] base);
      logic [31:0] exp[$];
      logic [11:0] lv;
      logic [3:0]  ch;
      logic        lo;
      bus(1'b1, cazs_pkg::OFS_CTRL, {29'h0, s, r, k});
      lvl <= base;
      gate <= 1'b1;
      repeat (10) @(posedge clock_i);
      gate <= 1'b0;
      evn++;
      while (busy !== 1'b0)
      begin
         @(posedge clock_i);
      end
      for (int i = 0; i < 32; i++)
      begin
         ch = {i[0], i[4:2]};
         lv = base + {4'h0, ch, 4'h0} + {8'h00, i[1], 3'h0};
         lo = r ? (lv[11:9] == 3'h0 && lv[8:1] < thr) : (lv[11:4] < thr);
         if (ch != 4'h5 && ch != 4'h9 && (!lo || k) && (!s || lv <= cazs_pkg::SLIDE_MAX))
            exp.push_back({11'h0, ch, i[1], 2'h0, lo, 1'b0, lv});
      end
      exp.push_front({5'h0, cazs_pkg::TYPE_HEAD, 10'h0, 6'(exp.size()), 8'h0});
      exp.push_back({5'h0, cazs_pkg::TYPE_EOB, 24'(evn)});
      foreach (exp[i])
      begin
         bus(1'b0, 16'(i * 4), '0);
         check(rdat, exp[i]);
      end
      bus(1'b0, 16'h0000, '0);
      check({29'h0, rdat[26:24]}, {29'h0, cazs_pkg::TYPE_INV});
   endtask
   task t_regs;
      bus(1'b0, cazs_pkg::OFS_THR + 16'h000c, '0);
      check(rdat, 32'h0000_0000);
      bus(1'b0, 16'h2000, '0);
      check(rdat, 32'h0000_0000);
      for (int c = 0; c < 16; c++)
         bus(1'b1, cazs_pkg::OFS_THR + 16'(c * 4), {23'h0, c == 9, thr});
      bus(1'b0, cazs_pkg::OFS_THR + 16'h0024, '0);
      check(rdat, {23'h0, 1'b1, thr});
      $display("test regs done");
   endtask
   task t_coarse;
      event_run(1'b0, 1'b0, 1'b0, 12'h100);
      $display("test coarse done");
   endtask
   task t_keep;
      event_run(1'b1, 1'b0, 1'b0, 12'h100);
      $display("test keep done");
   endtask
   task t_fine;
      slow <= 1'b1;
      event_run(1'b1, 1'b1, 1'b0, 12'h010);
      slow <= 1'b0;
      $display("test fine done");
   endtask
   task t_slide;
      event_run(1'b0, 1'b0, 1'b1, 12'he80);
      $display("test slide done");
   endtask
   task t_status;
      bus(1'b0, cazs_pkg::OFS_EVCNT, '0);
      check(rdat, 32'(evn));
      bus(1'b0, cazs_pkg::OFS_STAT, '0);
      check(rdat, 32'h0000_0000);
      bus(1'b1, cazs_pkg::OFS_CTRL, 32'h0000_000d);
      bus(1'b0, cazs_pkg::OFS_CTRL, '0);
      check(rdat, 32'h0000_0005);
      bus(1'b0, cazs_pkg::OFS_EVCNT, '0);
      check(rdat, 32'h0000_0000);
      $display("test status done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      t_regs;
      t_coarse;
      t_keep;
      t_fine;
      t_slide;
      t_status;
      close_out;
   end
   initial
   begin
      repeat (20000) @(posedge clock_i);
      bad_count++;
      close_out;
   end
endmodule // test_charge_adc_zero_suppression
`default_nettype wire
